// ### drsc_encoder.sv
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - antenna stays on receive; transmit path only while transmit enable is set.
// - transmit enable powers the transmit chain; otherwise it is unpowered.
// - on enable, check for faults before transmitting.
// - square bit clock to processor at low or high rate per rate select.
// - three-bit power control selects attenuation below full power.
// - receive enable activates gain control, bit sync, end-of-preamble detection.
// - end-of-preamble indication marks start of received data.
// - received data delivered after preamble with receive bit clock.
// - per-detector receive lines; carrier sense is OR of all detectors.
// - each bit spreads to 128 chips low rate, 32 chips high rate.
// - transmit chain operational within one bit; first bit may be garbled.
// - bit clock forwarded only while no fault such as lost lock.
// - incoming data and timing resynchronised to local bit timing.
// - counter addresses code table, rate select extra address bit.
// - one chip per chip interval; fast logic active only in transmit.
// - data one inverts code versus previous pattern; zero does not.
// - one positive or negative pulse per chip, from the code.
// - transmit dividers run from reference clock, enabled by transmit enable.

module drsc_sync3 #(
  parameter int W = 1
) (
  input wire logic clk_in, // sampling clock
  input wire logic arst_n_in, // async reset, active low
  input wire logic [W-1:0] d_in, // asynchronous inputs
  output logic [W-1:0] q_out // filtered, synchronised
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] q_r;

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= d_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // bit changes only once stages two and three agree
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      q_r <= '0;
    end else begin
      q_r <= (s2_r & s3_r) | (q_r & (s2_r | s3_r));
    end
  end

  assign q_out = q_r;
endmodule

module drsc_encoder (
  input wire logic ref_clk_in, // 40 MHz reference
  input wire logic arst_n_in, // async reset, active low
  input wire logic [3:0] avs_address_in, // byte address
  input wire logic avs_read_in, // read request
  input wire logic avs_write_in, // write request
  input wire logic [31:0] avs_writedata_in, // write data
  input wire logic [3:0] avs_byteenable_in, // byte lanes
  output logic [31:0] avs_readdata_out, // read data
  output logic avs_waitrequest_out, // stall
  input wire logic tx_clk_return_in, // returned bit clock
  input wire logic tx_data_in, // transmit data
  input wire logic synth_lock_in, // synthesiser locked
  output logic bit_clk_out, // bit clock to processor
  output logic antenna_tx_out, // antenna path on transmit
  output logic tx_power_out, // transmit chain power
  output logic [2:0] power_ctrl_out, // attenuation step
  output logic chip_pos_out, // positive chip pulse
  output logic chip_neg_out, // negative chip pulse
  output logic rx_enable_out, // gain, sync, preamble detect enable
  input wire logic [drsc_pkg::NDET-1:0] det_preamble_end_in, // per detector
  input wire logic [drsc_pkg::NDET-1:0] det_data_in, // per detector
  input wire logic [drsc_pkg::NDET-1:0] det_bit_clk_in, // per detector
  input wire logic [drsc_pkg::NDET-1:0] det_lock_in, // per detector
  output logic [drsc_pkg::NDET-1:0] preamble_done_out, // per detector
  output logic [drsc_pkg::NDET-1:0] rx_data_out, // per detector
  output logic [drsc_pkg::NDET-1:0] rx_bit_clk_out, // per detector
  output logic carrier_sense_out // any detector locked
);
  localparam int ND = drsc_pkg::NDET;

  drsc_pkg::drsc_ctrl_s ctrl_r;
  drsc_pkg::drsc_status_s status_w;
  drsc_pkg::drsc_state_e state_r;
  logic ack_r;
  logic [31:0] rdata_r;
  logic wr_fire;
  logic fault_seen_r;
  logic [15:0] bits_r;
  logic [2:0] tx_sync;
  logic txclk_s;
  logic txdat_s;
  logic lock_s;
  logic txclk_d_r;
  logic data_hold_r;
  logic [4*ND-1:0] det_sync;
  logic [ND-1:0] det_pe_s;
  logic [ND-1:0] det_dat_s;
  logic [ND-1:0] det_clk_s;
  logic [ND-1:0] det_lock_s;
  logic rate_tx_r;
  logic [1:0] chip_div_r;
  logic chip_en;
  logic [6:0] chip_cnt_r;
  logic bit_end;
  logic [4:0] check_cnt_r;
  logic pol_r;
  logic first_r;
  logic code_bit;
  logic [127:0] code_sel;
  logic chip_pos_r;
  logic chip_neg_r;
  logic bit_clk_r;
  logic ant_r;
  logic pwr_r;
  logic rx_en_r;
  logic [ND-1:0] pe_r;
  logic [ND-1:0] rxd_r;
  logic [ND-1:0] rxc_r;
  logic cs_r;
  logic active;

  // bus slave: one wait cycle, answer on the second edge
  assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack_r;
  assign wr_fire = avs_write_in & ack_r;

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (avs_read_in | avs_write_in) & ~ack_r;
    end
  end

  always_comb begin
    status_w = '0;
    status_w.state = state_r;
    status_w.carrier = cs_r;
    status_w.lock = lock_s;
    status_w.running = (state_r == drsc_pkg::ST_RUN);
    status_w.fault_seen = fault_seen_r;
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rdata_r <= 32'h0000_0000;
    end else if (avs_read_in && !ack_r) begin
      case (avs_address_in)
        drsc_pkg::CTRL_OFS: rdata_r <= {26'h0, ctrl_r};
        drsc_pkg::STATUS_OFS: rdata_r <= {24'h0, status_w};
        drsc_pkg::BITS_OFS: rdata_r <= {16'h0, bits_r};
        default: rdata_r <= 32'h0000_0000;
      endcase
    end
  end
  assign avs_readdata_out = rdata_r;

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ctrl_r <= drsc_pkg::CTRL_RST;
    end else if (wr_fire && avs_address_in == drsc_pkg::CTRL_OFS && avs_byteenable_in[0]) begin
      ctrl_r <= avs_writedata_in[drsc_pkg::CTRL_W-1:0];
    end
  end

  // fault flag: a new fault beats a clear in the same cycle
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      fault_seen_r <= 1'b0;
    end else if (state_r != drsc_pkg::ST_FAULT && active && !lock_s) begin
      fault_seen_r <= 1'b1;
    end else if (wr_fire && avs_address_in == drsc_pkg::STATUS_OFS && avs_byteenable_in[0]
                 && avs_writedata_in[drsc_pkg::FAULT_BIT]) begin
      fault_seen_r <= 1'b0;
    end
  end

  // pins from the processor and synthesiser
  drsc_sync3 #(.W(3)) u_tx_sync (
    .clk_in(ref_clk_in),
    .arst_n_in(arst_n_in),
    .d_in({synth_lock_in, tx_data_in, tx_clk_return_in}),
    .q_out(tx_sync)
  );
  assign txclk_s = tx_sync[0];
  assign txdat_s = tx_sync[1];
  assign lock_s = tx_sync[2];

  drsc_sync3 #(.W(4 * ND)) u_det_sync (
    .clk_in(ref_clk_in),
    .arst_n_in(arst_n_in),
    .d_in({det_lock_in, det_bit_clk_in, det_data_in, det_preamble_end_in}),
    .q_out(det_sync)
  );
  assign det_pe_s = det_sync[ND-1:0];
  assign det_dat_s = det_sync[2*ND-1:ND];
  assign det_clk_s = det_sync[3*ND-1:2*ND];
  assign det_lock_s = det_sync[4*ND-1:3*ND];

  // capture data mid-bit at the falling edge of the returned clock,
  // whatever the cable delay; used at the next local bit boundary
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      txclk_d_r <= 1'b0;
      data_hold_r <= 1'b0;
    end else begin
      txclk_d_r <= txclk_s;
      if (txclk_d_r && !txclk_s) begin
        data_hold_r <= txdat_s;
      end
    end
  end

  // transmit sequencing
  assign active = (state_r == drsc_pkg::ST_CHECK) || (state_r == drsc_pkg::ST_RUN);

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_r <= drsc_pkg::ST_OFF;
      check_cnt_r <= 5'h00;
      rate_tx_r <= 1'b0;
    end else begin
      case (state_r)
        drsc_pkg::ST_OFF: begin
          check_cnt_r <= 5'h00;
          if (ctrl_r.tx_en) begin
            rate_tx_r <= ctrl_r.rate;
            state_r <= drsc_pkg::ST_CHECK;
          end
        end
        drsc_pkg::ST_CHECK: begin
          check_cnt_r <= check_cnt_r + 5'h01;
          if (!ctrl_r.tx_en) begin
            state_r <= drsc_pkg::ST_OFF;
          end else if (!lock_s) begin
            state_r <= drsc_pkg::ST_FAULT;
          end else if (check_cnt_r == drsc_pkg::CHECK_LAST) begin
            state_r <= drsc_pkg::ST_RUN;
          end
        end
        drsc_pkg::ST_RUN: begin
          if (!ctrl_r.tx_en) begin
            state_r <= drsc_pkg::ST_OFF;
          end else if (!lock_s) begin
            state_r <= drsc_pkg::ST_FAULT;
          end
        end
        drsc_pkg::ST_FAULT: begin
          if (!ctrl_r.tx_en) begin
            state_r <= drsc_pkg::ST_OFF;
          end
        end
        default: state_r <= drsc_pkg::ST_OFF;
      endcase
    end
  end

  // chip-rate divider, held still unless transmitting
  assign chip_en = active && (chip_div_r == drsc_pkg::CHIP_LAST);

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      chip_div_r <= 2'h0;
    end else if (!active || chip_en) begin
      chip_div_r <= 2'h0;
    end else begin
      chip_div_r <= chip_div_r + 2'h1;
    end
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      chip_cnt_r <= 7'h00;
    end else if (!active) begin
      chip_cnt_r <= 7'h00;
    end else if (chip_en) begin
      chip_cnt_r <= chip_cnt_r + 7'h01;
    end
  end

  assign bit_end = chip_en && (rate_tx_r ? (chip_cnt_r[4:0] == drsc_pkg::HIGH_LAST)
                                         : (chip_cnt_r == drsc_pkg::LOW_LAST));

  // code table addressed by counter and rate
  assign code_sel = rate_tx_r ? drsc_pkg::HIGH_CODE_X4 : drsc_pkg::LOW_CODE;
  assign code_bit = code_sel[chip_cnt_r];

  // differential encoding: one inverts the pattern, zero keeps it
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pol_r <= 1'b0;
      first_r <= 1'b1;
    end else if (state_r != drsc_pkg::ST_RUN) begin
      pol_r <= 1'b0;
      first_r <= 1'b1;
    end else if (bit_end) begin
      first_r <= 1'b0;
      if (!first_r) begin
        pol_r <= pol_r ^ data_hold_r;
      end else begin
        pol_r <= pol_r ^ data_hold_r;
      end
    end
  end

  // one pulse per chip, sign from code and polarity
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      chip_pos_r <= 1'b0;
      chip_neg_r <= 1'b0;
    end else if (chip_en && state_r == drsc_pkg::ST_RUN) begin
      chip_pos_r <= code_bit ^ pol_r;
      chip_neg_r <= ~(code_bit ^ pol_r);
    end else begin
      chip_pos_r <= 1'b0;
      chip_neg_r <= 1'b0;
    end
  end
  assign chip_pos_out = chip_pos_r;
  assign chip_neg_out = chip_neg_r;

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      bits_r <= 16'h0000;
    end else if (state_r == drsc_pkg::ST_OFF && ctrl_r.tx_en) begin
      bits_r <= 16'h0000;
    end else if (bit_end && state_r == drsc_pkg::ST_RUN) begin
      bits_r <= bits_r + 16'h0001;
    end
  end

  // bit clock high in the first half of each bit, gated by faults
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      bit_clk_r <= 1'b0;
    end else if (state_r == drsc_pkg::ST_RUN && lock_s) begin
      bit_clk_r <= rate_tx_r ? ~chip_cnt_r[drsc_pkg::HIGH_MSB]
                             : ~chip_cnt_r[drsc_pkg::LOW_MSB];
    end else begin
      bit_clk_r <= 1'b0;
    end
  end
  assign bit_clk_out = bit_clk_r;

  // antenna, power and attenuation
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ant_r <= 1'b0;
      pwr_r <= 1'b0;
    end else begin
      ant_r <= ctrl_r.tx_en && active;
      pwr_r <= ctrl_r.tx_en;
    end
  end
  assign antenna_tx_out = ant_r;
  assign tx_power_out = pwr_r;
  assign power_ctrl_out = ctrl_r.power;

  // receive side, idle while transmitting
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rx_en_r <= 1'b0;
      pe_r <= '0;
      rxd_r <= '0;
      rxc_r <= '0;
      cs_r <= 1'b0;
    end else begin
      rx_en_r <= ctrl_r.rx_en && !ctrl_r.tx_en;
      if (rx_en_r) begin
        pe_r <= det_pe_s;
        rxd_r <= det_dat_s & det_pe_s;
        rxc_r <= det_clk_s;
        cs_r <= |det_lock_s;
      end else begin
        pe_r <= '0;
        rxd_r <= '0;
        rxc_r <= '0;
        cs_r <= 1'b0;
      end
    end
  end
  assign rx_enable_out = rx_en_r;
  assign preamble_done_out = pe_r;
  assign rx_data_out = rxd_r;
  assign rx_bit_clk_out = rxc_r;
  assign carrier_sense_out = cs_r;
endmodule
`default_nettype wire

// ### drsc_encoder_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module drsc_encoder_checker (
  input wire logic ref_clk_in, // clock
  input wire logic arst_n_in, // reset
  input wire logic avs_read_in, // read
  input wire logic avs_write_in, // write
  input wire logic avs_waitrequest_out, // stall
  input wire logic synth_lock_in, // lock
  input wire logic bit_clk_out, // bit clock
  input wire logic antenna_tx_out, // antenna
  input wire logic tx_power_out, // power
  input wire logic chip_pos_out, // pulse
  input wire logic chip_neg_out, // pulse
  input wire logic rx_enable_out, // rx on
  input wire logic [drsc_pkg::NDET-1:0] det_lock_in, // locks
  input wire logic [drsc_pkg::NDET-1:0] preamble_done_out, // eop
  input wire logic [drsc_pkg::NDET-1:0] rx_data_out, // data
  input wire logic carrier_sense_out // carrier
);
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!arst_n_in);
  wire logic pulse = chip_pos_out | chip_neg_out;
  wire logic req = avs_read_in | avs_write_in;
  sequence s_pulse;
    pulse;
  endsequence
  sequence s_quiet;
    !pulse ##1 !pulse;
  endsequence
  a_pulse_one: assert property (!(chip_pos_out && chip_neg_out))
    else $error("both chip pulses high");
  a_pulse_gap: assert property (s_pulse |=> s_quiet)
    else $error("chip pulses too close");
  a_chip_tx: assert property (pulse |-> $past(tx_power_out) && $past(antenna_tx_out))
    else $error("chip pulse without transmit");
  a_bitclk_tx: assert property (bit_clk_out |-> $past(tx_power_out))
    else $error("bit clock without transmit");
  a_bitclk_hold: assert property ($rose(bit_clk_out) |=> bit_clk_out [*8])
    else $error("bit clock high phase short");
  a_lock_stop: assert property (!synth_lock_in [*8] |-> !bit_clk_out && !pulse)
    else $error("transmit runs without lock");
  a_rx_excl: assert property (rx_enable_out |-> !tx_power_out)
    else $error("receive enabled in transmit");
  a_carrier_off: assert property (!(|det_lock_in) [*8] |-> !carrier_sense_out)
    else $error("carrier without lock");
  a_rxdata_gate: assert property ((rx_data_out & ~preamble_done_out) == '0)
    else $error("receive data before preamble end");
  a_wait_first: assert property ($rose(req) |-> avs_waitrequest_out)
    else $error("no wait cycle");
  a_wait_one: assert property (req && avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("wait longer than one cycle");
endmodule
`default_nettype wire

// ### drsc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module drsc_host_model #(
  parameter int DELAY_CYC = 8
) (
  input wire logic clk_in, // reference clock
  input wire logic arst_n_in, // reset
  input wire logic bit_clk_in, // clock from radio
  input wire logic data_in, // level to send
  output logic tx_clk_out, // returned clock
  output logic tx_data_out // transmit data
);
  logic [DELAY_CYC-1:0] line_r;
  // cable delay on the turned-around clock
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      line_r <= '0;
    end else begin
      line_r <= {line_r[DELAY_CYC-2:0], bit_clk_in};
    end
  end
  assign tx_clk_out = line_r[DELAY_CYC-1];
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      tx_data_out <= 1'b0;
    end else if (line_r[DELAY_CYC-1:DELAY_CYC-2] == 2'b01) begin
      tx_data_out <= data_in;
    end
  end
endmodule
`default_nettype wire

// ### drsc_pkg.sv
package drsc_pkg;

  // timing, all at the 40 MHz reference clock
  localparam int CLK_PERIOD_PS = 25000;
  localparam int CHIP_NS = 78;
  localparam int CHIP_CYC = (CHIP_NS * 1000) / CLK_PERIOD_PS;
  localparam int CHECK_NS = 500;
  localparam int CHECK_CYC = (CHECK_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [1:0] CHIP_LAST = 2'(CHIP_CYC - 1);
  localparam logic [4:0] CHECK_LAST = 5'(CHECK_CYC - 1);

  // spreading
  localparam int LOW_CHIPS = 128;
  localparam int HIGH_CHIPS = 32;
  localparam logic [6:0] LOW_LAST = 7'(LOW_CHIPS - 1);
  localparam logic [4:0] HIGH_LAST = 5'(HIGH_CHIPS - 1);
  localparam int LOW_MSB = 6;
  localparam int HIGH_MSB = 4;
  localparam logic [127:0] LOW_CODE = 128'h3a5c_96e1_0f4b_d287_c5a3_691e_f0b4_2d78;
  localparam logic [31:0] HIGH_CODE = 32'h9d2c_5e3a;
  localparam logic [127:0] HIGH_CODE_X4 = {4{HIGH_CODE}};

  // detectors
  localparam int NDET = 2;

  // register map, byte offsets
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] STATUS_OFS = 4'h4;
  localparam logic [3:0] BITS_OFS = 4'h8;

  // control register layout, bit 0 = tx_en
  typedef struct packed {
    logic [2:0] power;
    logic rx_en;
    logic rate;
    logic tx_en;
  } drsc_ctrl_s;
  localparam int CTRL_W = 6;
  localparam logic [5:0] CTRL_RST = 6'h00;

  // status register layout, bit 0 = fault_seen (write one to clear)
  typedef struct packed {
    logic [3:0] state;
    logic carrier;
    logic lock;
    logic running;
    logic fault_seen;
  } drsc_status_s;
  localparam int STATUS_W = 8;
  localparam int FAULT_BIT = 0;

  typedef enum logic [3:0] {
    ST_OFF = 4'b0001,
    ST_CHECK = 4'b0010,
    ST_RUN = 4'b0100,
    ST_FAULT = 4'b1000
  } drsc_state_e;

endpackage

// ### test_dual_rate_spread_chip_encoder.sv
`timescale 1ns/1ps
`default_nettype none
module test_dual_rate_spread_chip_encoder;
  logic ref_clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic [3:0] addr = 4'h0;
  logic rd = 1'b0, wr = 1'b0, lock = 1'b1, host_data = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic wait_req, ret_clk, tx_data, bit_clk, ant, pwr, cpos, cneg, rxen, cs;
  logic [2:0] pctl;
  logic [1:0] det_eop = 2'h0, det_dat = 2'h0, det_bclk = 2'h0, det_lk = 2'h0;
  logic [1:0] eop_o, dat_o, bclk_o;
  logic chips [0:255];
  int n_fail = 0;
  int check_count = 0;
  // lead-in code of the preamble, plain default
  localparam logic [8:0] LEAD_CODE = 9'h1ab;
  localparam logic [12:0] BARKER13 = 13'h1f35;
  always #12.5 ref_clk_in = ~ref_clk_in;
  drsc_encoder i_drsc_encoder (.ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in),
    .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
    .avs_byteenable_in(4'hf), .avs_readdata_out(rdata), .avs_waitrequest_out(wait_req),
    .tx_clk_return_in(ret_clk), .tx_data_in(tx_data), .synth_lock_in(lock),
    .bit_clk_out(bit_clk), .antenna_tx_out(ant), .tx_power_out(pwr), .power_ctrl_out(pctl),
    .chip_pos_out(cpos), .chip_neg_out(cneg), .rx_enable_out(rxen),
    .det_preamble_end_in(det_eop), .det_data_in(det_dat), .det_bit_clk_in(det_bclk),
    .det_lock_in(det_lk), .preamble_done_out(eop_o), .rx_data_out(dat_o),
    .rx_bit_clk_out(bclk_o), .carrier_sense_out(cs));
  drsc_host_model i_drsc_host_model (.clk_in(ref_clk_in), .arst_n_in(arst_n_in),
    .bit_clk_in(bit_clk), .data_in(host_data), .tx_clk_out(ret_clk), .tx_data_out(tx_data));
  task automatic complete_run();
    if (n_fail == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic compare(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int t;
    t = 0;
    @(posedge ref_clk_in);
    addr <= a;
    wdata <= d;
    rd <= !w;
    wr <= w;
    do begin
      @(posedge ref_clk_in);
      t++;
    end while (wait_req !== 1'b0 && t < 50);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    compare("bus answer", 1, t < 50);
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd_chk(input string what, input logic [3:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    compare(what, exp, q);
  endtask
  task automatic wait_bclk(input logic v);
    int t;
    t = 0;
    while (bit_clk !== v && t < 2000) begin
      @(negedge ref_clk_in);
      t++;
    end
    compare("bit clock edge", 1, t < 2000);
  endtask
  task automatic capture(input int nb, output int nc, output int cyc);
    logic prev;
    int r;
    wait_bclk(1'b0);
    wait_bclk(1'b1);
    nc = 0;
    cyc = 0;
    r = 0;
    prev = 1'b1;
    while (r < nb && cyc < 4000) begin
      @(negedge ref_clk_in);
      cyc++;
      if (cpos === 1'b1 || cneg === 1'b1) begin
        if (nc < 256) chips[nc] = cpos;
        nc++;
      end
      if (bit_clk === 1'b1 && prev === 1'b0) r++;
      prev = bit_clk;
    end
  endtask
  task automatic t_reset();
    repeat (5) @(posedge ref_clk_in);
    compare("idle outputs", 0, {ant, pwr, bit_clk, rxen});
    rd_chk("ctrl reset", drsc_pkg::CTRL_OFS, 32'h0);
    rd_chk("status reset", drsc_pkg::STATUS_OFS, 32'h14);
    wr_reg(4'hc, 32'hff);
    rd_chk("unmapped", 4'hc, 32'h0);
    rd_chk("ctrl kept", drsc_pkg::CTRL_OFS, 32'h0);
  endtask
  task automatic t_tx(input logic rate);
    int n, nc, cyc, t, bad;
    n = rate ? drsc_pkg::HIGH_CHIPS : drsc_pkg::LOW_CHIPS;
    wr_reg(drsc_pkg::CTRL_OFS, {30'h0, rate, 1'b1});
    repeat (3) @(negedge ref_clk_in);
    compare("tx on", 3'b110, {ant, pwr, bit_clk});
    t = 3;
    while (cpos !== 1'b1 && cneg !== 1'b1 && t < 1000) begin
      @(negedge ref_clk_in);
      t++;
    end
    compare("turn on time", 1, t < 3 * n);
    rd_chk("status run", drsc_pkg::STATUS_OFS, 32'h46);
    for (int d = 0; d < 2; d++) begin
      @(posedge ref_clk_in);
      host_data <= d[0];
      capture(3, nc, cyc);
      capture(2, nc, cyc);
      compare("chips per bit", 2 * n, nc);
      compare("bit period", 6 * n, cyc);
      bad = 0;
      for (int i = 0; i < n; i++) begin
        if ((chips[i] ^ chips[i + n]) !== d[0]) bad++;
      end
      compare("code inversion", 0, bad);
    end
    wait_bclk(1'b1);
    wait_bclk(1'b0);
    wr_reg(drsc_pkg::CTRL_OFS, 32'h0);
    repeat (3) @(negedge ref_clk_in);
    compare("tx off", 0, {ant, pwr, bit_clk});
  endtask
  task automatic t_fault();
    int nc, cyc, seen;
    wr_reg(drsc_pkg::CTRL_OFS, 32'h3);
    capture(1, nc, cyc);
    wait_bclk(1'b0);
    @(posedge ref_clk_in);
    lock <= 1'b0;
    repeat (8) @(negedge ref_clk_in);
    seen = 0;
    repeat (20) begin
      @(negedge ref_clk_in);
      if (bit_clk !== 1'b0 || cpos !== 1'b0 || cneg !== 1'b0) seen++;
    end
    compare("stopped on fault", 0, seen);
    rd_chk("status fault", drsc_pkg::STATUS_OFS, 32'h81);
    wr_reg(drsc_pkg::CTRL_OFS, 32'h0);
    lock <= 1'b1;
    repeat (6) @(posedge ref_clk_in);
    wr_reg(drsc_pkg::STATUS_OFS, 32'h1);
    rd_chk("fault cleared", drsc_pkg::STATUS_OFS, 32'h14);
    lock <= 1'b0;
    repeat (6) @(posedge ref_clk_in);
    wr_reg(drsc_pkg::CTRL_OFS, 32'h3);
    repeat (30) @(negedge ref_clk_in);
    compare("no start unlocked", 0, bit_clk);
    rd_chk("status check fail", drsc_pkg::STATUS_OFS, 32'h81);
    wr_reg(drsc_pkg::CTRL_OFS, 32'h0);
    lock <= 1'b1;
    repeat (6) @(posedge ref_clk_in);
    wr_reg(drsc_pkg::STATUS_OFS, 32'h1);
  endtask
  task automatic t_preamble();
    logic [47:0] pre;
    logic prev, c;
    pre = {~LEAD_CODE, ~BARKER13, ~BARKER13, BARKER13};
    prev = 1'b0;
    wr_reg(drsc_pkg::CTRL_OFS, 32'h3);
    wait_bclk(1'b1);
    for (int j = 0; j <= 48; j++) begin
      wait_bclk(1'b0);
      wait_bclk(1'b1);
      @(posedge ref_clk_in);
      if (j < 48) host_data <= pre[47 - j];
      // first chip of the bit is on the pins here
      repeat (2) @(negedge ref_clk_in);
      c = cpos;
      compare("preamble chip", 1, cpos ^ cneg);
      if (j > 0) compare("preamble bit", pre[48 - j], c ^ prev);
      prev = c;
    end
    rd_chk("bits sent", drsc_pkg::BITS_OFS, 32'h31);
    wr_reg(drsc_pkg::CTRL_OFS, 32'h0);
    host_data <= 1'b0;
  endtask
  task automatic t_rx();
    @(posedge ref_clk_in);
    det_lk <= 2'h2;
    det_eop <= 2'h1;
    det_dat <= 2'h3;
    det_bclk <= 2'h2;
    wr_reg(drsc_pkg::CTRL_OFS, 32'h2c);
    repeat (6) @(negedge ref_clk_in);
    compare("rx enable", 1, rxen);
    compare("power ctrl", 3'h5, pctl);
    compare("carrier", 1, cs);
    compare("preamble end", 2'h1, eop_o);
    compare("rx data", 2'h1, dat_o);
    compare("rx clock", 2'h2, bclk_o);
    rd_chk("ctrl readback", drsc_pkg::CTRL_OFS, 32'h2c);
    rd_chk("status carrier", drsc_pkg::STATUS_OFS, 32'h1c);
    det_lk <= 2'h0;
    repeat (6) @(negedge ref_clk_in);
    compare("carrier off", 0, cs);
    wr_reg(drsc_pkg::CTRL_OFS, 32'h2d);
    repeat (2) @(negedge ref_clk_in);
    compare("rx off in tx", 2'b01, {rxen, pwr});
    wr_reg(drsc_pkg::CTRL_OFS, 32'h0);
  endtask
  initial begin
    repeat (10) @(posedge ref_clk_in);
    arst_n_in <= 1'b1;
    t_reset();
    t_tx(1'b1);
    t_tx(1'b0);
    t_fault();
    t_preamble();
    t_rx();
    complete_run();
  end
  initial begin
    repeat (60000) @(posedge ref_clk_in);
    n_fail++;
    complete_run();
  end
endmodule
bind drsc_encoder drsc_encoder_checker i_drsc_encoder_checker (.ref_clk_in(ref_clk_in),
  .arst_n_in(arst_n_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
  .avs_waitrequest_out(avs_waitrequest_out), .synth_lock_in(synth_lock_in),
  .bit_clk_out(bit_clk_out), .antenna_tx_out(antenna_tx_out), .tx_power_out(tx_power_out),
  .chip_pos_out(chip_pos_out), .chip_neg_out(chip_neg_out), .rx_enable_out(rx_enable_out),
  .det_lock_in(det_lock_in), .preamble_done_out(preamble_done_out),
  .rx_data_out(rx_data_out), .carrier_sense_out(carrier_sense_out));
`default_nettype wire
